// File: pkg/lsbd_map.svh
// opcode patterns, sub-field codes and fixed lengths for the logic/string/branch decoder
`ifndef LSBD_MAP_SVH
`define LSBD_MAP_SVH

// masks that drop the width bit, the width and direction bits, or no bit at all
`define LSBD_MASK_W 8'hFE
`define LSBD_MASK_DW 8'hFC
`define LSBD_MASK_ALL 8'hFF

// shift and rotate group, 110100vw
`define LSBD_PAT_SHIFT 8'hD0
// logic forms with an addressing-mode byte
`define LSBD_PAT_AND 8'h20
`define LSBD_PAT_OR 8'h08
`define LSBD_PAT_XOR 8'h30
// flag-only and forms
`define LSBD_PAT_TEST_REG 8'h84
`define LSBD_PAT_TEST_IMM 8'hF6
`define LSBD_PAT_TEST_ACC 8'hA8
// string primitives and repeat prefix
`define LSBD_PAT_STR_MOVE 8'hA4
`define LSBD_PAT_STR_CMP 8'hA6
`define LSBD_PAT_STR_SCAN 8'hAE
`define LSBD_PAT_STR_LOAD 8'hAC
`define LSBD_PAT_STR_WRITE 8'hAA
`define LSBD_PAT_REPEAT 8'hF2
// procedure exits
`define LSBD_PAT_EXIT_NEAR 8'hC3
`define LSBD_PAT_EXIT_NEAR_IMM 8'hC2
`define LSBD_PAT_EXIT_FAR 8'hCB
`define LSBD_PAT_EXIT_FAR_IMM 8'hCA
// short conditional branches
`define LSBD_PAT_BR_EQUAL 8'h74
`define LSBD_PAT_BR_LESS 8'h7C
`define LSBD_PAT_BR_LESS_EQ 8'h7E
`define LSBD_PAT_BR_BELOW 8'h72
`define LSBD_PAT_BR_BELOW_EQ 8'h76

// middle field codes of the shift group and of the immediate flag-only and
`define LSBD_SUB_ROT_LEFT 3'h0
`define LSBD_SUB_ROT_RIGHT 3'h1
`define LSBD_SUB_ROT_LEFT_C 3'h2
`define LSBD_SUB_ROT_RIGHT_C 3'h3
`define LSBD_SUB_SHIFT_LEFT 3'h4
`define LSBD_SUB_LOGIC_RIGHT 3'h5
`define LSBD_SUB_ARITH_RIGHT 3'h7
`define LSBD_SUB_FLAG_AND 3'h0

// fixed lengths in bytes and the single shift count
`define LSBD_LEN_ONE 4'h1
`define LSBD_LEN_MODRM 4'h2
`define LSBD_LEN_IMM16 4'h3
`define LSBD_LEN_NONE 4'h0
`define LSBD_SINGLE_COUNT 8'h01

`endif

// File: pkg/lsbd_pkg.sv
// types shared by the decoder files
package lsbd_pkg;
	// coarse instruction class
	typedef enum logic [2:0] {
		CLS_NONE, CLS_PREFIX, CLS_SHIFT, CLS_LOGIC, CLS_STRING, CLS_EXIT, CLS_BRANCH
	} lsbd_class_type;
	// exact operation
	typedef enum logic [4:0] {
		OP_NONE, OP_SHIFT_LEFT, OP_LOGIC_RIGHT, OP_ARITH_RIGHT,
		OP_ROT_LEFT, OP_ROT_RIGHT, OP_ROT_LEFT_C, OP_ROT_RIGHT_C,
		OP_AND, OP_OR, OP_XOR, OP_FLAG_AND,
		OP_STR_MOVE, OP_STR_COMPARE, OP_STR_SEARCH, OP_STR_LOAD, OP_STR_WRITE,
		OP_EXIT_NEAR, OP_EXIT_FAR,
		OP_BR_EQUAL, OP_BR_LESS, OP_BR_LESS_EQ, OP_BR_BELOW, OP_BR_BELOW_EQ
	} lsbd_op_type;
	// repeat prefix tracking
	typedef enum logic {ST_FRESH, ST_REPEATED} lsbd_state_type;
endpackage : lsbd_pkg

// File: rtl/lsbd_ea_len.sv
// displacement byte count implied by an addressing-mode byte
`timescale 1ns/100ps
`default_nettype none
module lsbd_ea_len (
	input wire logic has_modrm,
	input wire logic [1:0] mod_field,
	input wire logic [2:0] rm_field,
	output logic [1:0] disp_count
);
	////////////////////////////////////////////////////////////////
	// mod 00 has no displacement except the direct address form,
	// mod 01 one byte, mod 10 two bytes, mod 11 register operand
	always_comb begin
		disp_count = 2'h0;
		if (!has_modrm) begin
			// no addressing-mode byte, nothing follows
			disp_count = 2'h0;
		end else if (mod_field == 2'h0) begin
			// direct address takes a 16-bit offset
			disp_count = (rm_field == 3'h6) ? 2'h2 : 2'h0;
		end else if (mod_field == 2'h1) begin
			disp_count = 2'h1;
		end else if (mod_field == 2'h2) begin
			disp_count = 2'h2;
		end else begin
			// register operand
			disp_count = 2'h0;
		end
	end
endmodule : lsbd_ea_len
`default_nettype wire

// File: rtl/lsbd_decoder.sv
// logic, shift, string, return and short branch opcode decoder
`include "lsbd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module lsbd_decoder (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	input wire logic [7:0] byte0,
	input wire logic [7:0] byte1,
	input wire logic [7:0] byte2,
	input wire logic [7:0] byte3,
	input wire logic [7:0] byte4,
	input wire logic [7:0] byte5,
	input wire logic [15:0] instr_addr,
	input wire logic [7:0] count_low_byte,
	input wire logic flag_zero,
	input wire logic flag_sign,
	input wire logic flag_overflow,
	input wire logic flag_carry,
	output logic in_ready,
	output var logic out_valid_q,
	output var logic claimed_q,
	output var lsbd_pkg::lsbd_class_type class_q,
	output var lsbd_pkg::lsbd_op_type op_q,
	output var logic word_op_q,
	output var logic reg_is_dest_q,
	output var logic write_back_q,
	output var logic has_modrm_q,
	output var logic [1:0] mod_q,
	output var logic [2:0] reg_q,
	output var logic [2:0] rm_q,
	output var logic [15:0] disp_q,
	output var logic imm_valid_q,
	output var logic [15:0] imm_q,
	output var logic acc_operand_q,
	output var logic count_from_reg_q,
	output var logic [7:0] shift_count_q,
	output var logic repeat_q,
	output var logic repeat_zf_match_q,
	output var logic branch_taken_q,
	output var logic [15:0] branch_target_q,
	output var logic [15:0] stack_adjust_q,
	output var logic reload_code_seg_q,
	output var logic [3:0] length_q
);
	////////////////////////////////////////////////////////////////
	// byte window and field split
	logic [7:0] win [0:5]; // instruction bytes by position
	logic width_bit; // low opcode bit
	logic dir_bit; // second opcode bit, also count source
	logic [1:0] disp_cnt; // displacement bytes after modrm
	logic [2:0] imm_idx; // position of first data byte
	logic [15:0] ea_disp; // sign-extended displacement
	logic is_repeat; // byte0 is the repeat prefix
	logic modrm_form; // opcode carries an addressing-mode byte
	lsbd_pkg::lsbd_state_type state_q; // prefix tracking
	logic rep_z_q; // low bit of last repeat prefix

	// next values of the output registers
	logic claimed_d;
	lsbd_pkg::lsbd_class_type class_d;
	lsbd_pkg::lsbd_op_type op_d;
	logic reg_is_dest_d;
	logic write_back_d;
	logic has_modrm_d;
	logic imm_valid_d;
	logic [15:0] imm_d;
	logic acc_operand_d;
	logic branch_taken_d;
	logic [15:0] stack_adjust_d;
	logic reload_code_seg_d;
	logic [3:0] length_d;
	logic repeat_d;
	logic repeat_zf_match_d;

	// match an opcode against a pattern under a mask
	function automatic logic op_is(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
		return (b & m) == v;
	endfunction : op_is

	assign win[0] = byte0;
	assign win[1] = byte1;
	assign win[2] = byte2;
	assign win[3] = byte3;
	assign win[4] = byte4;
	assign win[5] = byte5;
	assign width_bit = byte0[0];
	assign dir_bit = byte0[1];
	assign is_repeat = op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_REPEAT);
	// addressing-mode forms from byte0 and the byte1 middle field alone, so the length path has no loop through decode
	assign modrm_form = (op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_SHIFT) && byte1[5:3] != 3'h6)
		|| op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_AND) || op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_OR)
		|| op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_XOR) || op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_TEST_REG)
		|| (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_TEST_IMM) && byte1[5:3] == `LSBD_SUB_FLAG_AND);
	// no stall: one instruction taken per cycle
	assign in_ready = 1'b1;

	// displacement length from the addressing-mode byte
	lsbd_ea_len u_ea_len (
		.has_modrm(modrm_form),
		.mod_field(byte1[7:6]),
		.rm_field(byte1[2:0]),
		.disp_count(disp_cnt)
	);

	// displacement value, data bytes sit after it
	always_comb begin
		ea_disp = 16'h0000;
		if (disp_cnt == 2'h1) begin
			ea_disp = {{8{byte2[7]}}, byte2};
		end else if (disp_cnt == 2'h2) begin
			ea_disp = {byte3, byte2};
		end
		imm_idx = 3'h2 + {1'b0, disp_cnt};
	end

	////////////////////////////////////////////////////////////////
	// opcode decode
	always_comb begin
		claimed_d = 1'b1;
		class_d = lsbd_pkg::CLS_NONE;
		op_d = lsbd_pkg::OP_NONE;
		reg_is_dest_d = 1'b0;
		write_back_d = 1'b0;
		has_modrm_d = 1'b0;
		imm_valid_d = 1'b0;
		imm_d = 16'h0000;
		acc_operand_d = 1'b0;
		branch_taken_d = 1'b0;
		stack_adjust_d = 16'h0000;
		reload_code_seg_d = 1'b0;
		length_d = `LSBD_LEN_ONE;
		if (is_repeat) begin
			// prefix is consumed alone
			class_d = lsbd_pkg::CLS_PREFIX;
		end else if (op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_SHIFT) && byte1[5:3] != 3'h6) begin
			// shift group, result goes back to the operand
			class_d = lsbd_pkg::CLS_SHIFT;
			has_modrm_d = 1'b1;
			write_back_d = 1'b1;
			length_d = `LSBD_LEN_MODRM + {2'b00, disp_cnt};
			case (byte1[5:3])
				`LSBD_SUB_SHIFT_LEFT: op_d = lsbd_pkg::OP_SHIFT_LEFT;
				`LSBD_SUB_LOGIC_RIGHT: op_d = lsbd_pkg::OP_LOGIC_RIGHT;
				`LSBD_SUB_ARITH_RIGHT: op_d = lsbd_pkg::OP_ARITH_RIGHT;
				`LSBD_SUB_ROT_LEFT: op_d = lsbd_pkg::OP_ROT_LEFT;
				`LSBD_SUB_ROT_RIGHT: op_d = lsbd_pkg::OP_ROT_RIGHT;
				`LSBD_SUB_ROT_LEFT_C: op_d = lsbd_pkg::OP_ROT_LEFT_C;
				default: op_d = lsbd_pkg::OP_ROT_RIGHT_C;
			endcase
		end else if (op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_AND) || op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_OR)
			|| op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_XOR)) begin
			// register with register or memory, direction bit steers
			class_d = lsbd_pkg::CLS_LOGIC;
			has_modrm_d = 1'b1;
			write_back_d = 1'b1;
			reg_is_dest_d = dir_bit;
			length_d = `LSBD_LEN_MODRM + {2'b00, disp_cnt};
			if (op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_AND)) begin
				op_d = lsbd_pkg::OP_AND;
			end else if (op_is(byte0, `LSBD_MASK_DW, `LSBD_PAT_OR)) begin
				op_d = lsbd_pkg::OP_OR;
			end else begin
				op_d = lsbd_pkg::OP_XOR;
			end
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_TEST_REG)) begin
			// flags only, nothing written
			class_d = lsbd_pkg::CLS_LOGIC;
			op_d = lsbd_pkg::OP_FLAG_AND;
			has_modrm_d = 1'b1;
			length_d = `LSBD_LEN_MODRM + {2'b00, disp_cnt};
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_TEST_IMM) && byte1[5:3] == `LSBD_SUB_FLAG_AND) begin
			// immediate after any displacement
			class_d = lsbd_pkg::CLS_LOGIC;
			op_d = lsbd_pkg::OP_FLAG_AND;
			has_modrm_d = 1'b1;
			imm_valid_d = 1'b1;
			imm_d = width_bit ? {win[imm_idx + 3'h1], win[imm_idx]} : {8'h00, win[imm_idx]};
			length_d = `LSBD_LEN_IMM16 + {2'b00, disp_cnt} + {3'b000, width_bit};
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_TEST_ACC)) begin
			// accumulator against data right after the opcode
			class_d = lsbd_pkg::CLS_LOGIC;
			op_d = lsbd_pkg::OP_FLAG_AND;
			acc_operand_d = 1'b1;
			imm_valid_d = 1'b1;
			imm_d = width_bit ? {byte2, byte1} : {8'h00, byte1};
			length_d = `LSBD_LEN_MODRM + {3'b000, width_bit};
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_STR_MOVE)) begin
			class_d = lsbd_pkg::CLS_STRING;
			op_d = lsbd_pkg::OP_STR_MOVE;
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_STR_CMP)) begin
			class_d = lsbd_pkg::CLS_STRING;
			op_d = lsbd_pkg::OP_STR_COMPARE;
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_STR_SCAN)) begin
			class_d = lsbd_pkg::CLS_STRING;
			op_d = lsbd_pkg::OP_STR_SEARCH;
			acc_operand_d = 1'b1;
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_STR_LOAD)) begin
			// element lands in the accumulator
			class_d = lsbd_pkg::CLS_STRING;
			op_d = lsbd_pkg::OP_STR_LOAD;
			acc_operand_d = 1'b1;
		end else if (op_is(byte0, `LSBD_MASK_W, `LSBD_PAT_STR_WRITE)) begin
			// element taken from the accumulator
			class_d = lsbd_pkg::CLS_STRING;
			op_d = lsbd_pkg::OP_STR_WRITE;
			acc_operand_d = 1'b1;
		end else if (op_is(byte0, `LSBD_MASK_ALL, `LSBD_PAT_EXIT_NEAR)) begin
			class_d = lsbd_pkg::CLS_EXIT;
			op_d = lsbd_pkg::OP_EXIT_NEAR;
		end else if (op_is(byte0, `LSBD_MASK_ALL, `LSBD_PAT_EXIT_FAR)) begin
			class_d = lsbd_pkg::CLS_EXIT;
			op_d = lsbd_pkg::OP_EXIT_FAR;
			reload_code_seg_d = 1'b1;
		end else if (op_is(byte0, `LSBD_MASK_ALL, `LSBD_PAT_EXIT_NEAR_IMM)) begin
			// low byte first
			class_d = lsbd_pkg::CLS_EXIT;
			op_d = lsbd_pkg::OP_EXIT_NEAR;
			stack_adjust_d = {byte2, byte1};
			length_d = `LSBD_LEN_IMM16;
		end else if (op_is(byte0, `LSBD_MASK_ALL, `LSBD_PAT_EXIT_FAR_IMM)) begin
			class_d = lsbd_pkg::CLS_EXIT;
			op_d = lsbd_pkg::OP_EXIT_FAR;
			reload_code_seg_d = 1'b1;
			stack_adjust_d = {byte2, byte1};
			length_d = `LSBD_LEN_IMM16;
		end else if (byte0 == `LSBD_PAT_BR_EQUAL) begin
			class_d = lsbd_pkg::CLS_BRANCH;
			op_d = lsbd_pkg::OP_BR_EQUAL;
			branch_taken_d = flag_zero;
			length_d = `LSBD_LEN_MODRM;
		end else if (byte0 == `LSBD_PAT_BR_LESS) begin
			class_d = lsbd_pkg::CLS_BRANCH;
			op_d = lsbd_pkg::OP_BR_LESS;
			branch_taken_d = flag_sign ^ flag_overflow;
			length_d = `LSBD_LEN_MODRM;
		end else if (byte0 == `LSBD_PAT_BR_LESS_EQ) begin
			class_d = lsbd_pkg::CLS_BRANCH;
			op_d = lsbd_pkg::OP_BR_LESS_EQ;
			branch_taken_d = flag_zero | (flag_sign ^ flag_overflow);
			length_d = `LSBD_LEN_MODRM;
		end else if (byte0 == `LSBD_PAT_BR_BELOW) begin
			class_d = lsbd_pkg::CLS_BRANCH;
			op_d = lsbd_pkg::OP_BR_BELOW;
			branch_taken_d = flag_carry;
			length_d = `LSBD_LEN_MODRM;
		end else if (byte0 == `LSBD_PAT_BR_BELOW_EQ) begin
			class_d = lsbd_pkg::CLS_BRANCH;
			op_d = lsbd_pkg::OP_BR_BELOW_EQ;
			branch_taken_d = flag_carry | flag_zero;
			length_d = `LSBD_LEN_MODRM;
		end else begin
			// opcode for a neighbouring decoder
			claimed_d = 1'b0;
			length_d = `LSBD_LEN_NONE;
		end
		// repeat applies to string primitives only
		repeat_d = (state_q == lsbd_pkg::ST_REPEATED) && (class_d == lsbd_pkg::CLS_STRING);
		repeat_zf_match_d = repeat_d && rep_z_q
			&& (op_d == lsbd_pkg::OP_STR_COMPARE || op_d == lsbd_pkg::OP_STR_SEARCH);
	end

	////////////////////////////////////////////////////////////////
	// repeat prefix tracking
	always_ff @(posedge clk) begin
		if (srst) begin
			state_q <= lsbd_pkg::ST_FRESH;
		end else if (in_valid) begin
			case (state_q)
				// prefix arms the next instruction
				lsbd_pkg::ST_FRESH: state_q <= is_repeat ? lsbd_pkg::ST_REPEATED : lsbd_pkg::ST_FRESH;
				// any instruction after it other than another prefix disarms
				default: state_q <= is_repeat ? lsbd_pkg::ST_REPEATED : lsbd_pkg::ST_FRESH;
			endcase
		end
	end

	// zero-flag match value of the prefix
	always_ff @(posedge clk) begin
		if (srst) begin
			rep_z_q <= 1'b0;
		end else if (in_valid && is_repeat) begin
			rep_z_q <= byte0[0];
		end
	end

	////////////////////////////////////////////////////////////////
	// result valid strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid_q <= 1'b0;
		end else begin
			out_valid_q <= in_valid;
		end
	end

	// decoded fields, held until the next instruction
	always_ff @(posedge clk) begin
		if (srst) begin
			claimed_q <= 1'b0;
			class_q <= lsbd_pkg::CLS_NONE;
			op_q <= lsbd_pkg::OP_NONE;
			word_op_q <= 1'b0;
			reg_is_dest_q <= 1'b0;
			write_back_q <= 1'b0;
			has_modrm_q <= 1'b0;
			mod_q <= 2'h0;
			reg_q <= 3'h0;
			rm_q <= 3'h0;
			disp_q <= 16'h0000;
			imm_valid_q <= 1'b0;
			imm_q <= 16'h0000;
			acc_operand_q <= 1'b0;
			length_q <= `LSBD_LEN_NONE;
			repeat_q <= 1'b0;
			repeat_zf_match_q <= 1'b0;
		end else if (in_valid) begin
			claimed_q <= claimed_d;
			class_q <= class_d;
			op_q <= op_d;
			word_op_q <= width_bit;
			reg_is_dest_q <= reg_is_dest_d;
			write_back_q <= write_back_d;
			has_modrm_q <= has_modrm_d;
			mod_q <= byte1[7:6];
			reg_q <= byte1[5:3];
			rm_q <= byte1[2:0];
			disp_q <= ea_disp;
			imm_valid_q <= imm_valid_d;
			imm_q <= imm_d;
			acc_operand_q <= acc_operand_d;
			length_q <= length_d;
			repeat_q <= repeat_d;
			repeat_zf_match_q <= repeat_zf_match_d;
		end
	end

	// shift count source
	always_ff @(posedge clk) begin
		if (srst) begin
			count_from_reg_q <= 1'b0;
			shift_count_q <= `LSBD_SINGLE_COUNT;
		end else if (in_valid) begin
			count_from_reg_q <= dir_bit;
			shift_count_q <= dir_bit ? count_low_byte : `LSBD_SINGLE_COUNT;
		end
	end

	// branch, stack and segment effects
	always_ff @(posedge clk) begin
		if (srst) begin
			branch_taken_q <= 1'b0;
			branch_target_q <= 16'h0000;
			stack_adjust_q <= 16'h0000;
			reload_code_seg_q <= 1'b0;
		end else if (in_valid) begin
			branch_taken_q <= branch_taken_d;
			// offset counts from the byte after the branch
			branch_target_q <= instr_addr + {12'h000, `LSBD_LEN_MODRM} + {{8{byte1[7]}}, byte1};
			stack_adjust_q <= stack_adjust_d;
			reload_code_seg_q <= reload_code_seg_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	a_shift_left_pick: assert property (
		in_valid && byte0[7:2] == 6'h34 && byte1[5:3] == 3'h4
		|=> class_q == lsbd_pkg::CLS_SHIFT && op_q == lsbd_pkg::OP_SHIFT_LEFT && write_back_q)
		else $error("shift left not decoded");
	a_rotate_carry_pick: assert property (
		in_valid && byte0[7:2] == 6'h34 && byte1[5:3] == 3'h3 |=> op_q == lsbd_pkg::OP_ROT_RIGHT_C)
		else $error("rotate right through carry not decoded");
	a_xor_direction: assert property (
		in_valid && byte0[7:2] == 6'h0C
		|=> op_q == lsbd_pkg::OP_XOR && reg_is_dest_q == $past(byte0[1]) && word_op_q == $past(byte0[0]))
		else $error("xor direction or width wrong");
	a_flag_and_nowrite: assert property (
		in_valid && byte0[7:1] == 7'h42 |=> op_q == lsbd_pkg::OP_FLAG_AND && !write_back_q)
		else $error("flag-only and writes back");
	a_imm_and_length: assert property (
		in_valid && byte0[7:1] == 7'h7B && byte1[7:3] == 5'h18
		|=> imm_valid_q && length_q == 4'h3 + {3'h0, $past(byte0[0])})
		else $error("immediate and length wrong");
	a_acc_imm_word: assert property (
		in_valid && byte0 == 8'hA9 |=> imm_q == {$past(byte2), $past(byte1)} && length_q == 4'h3)
		else $error("accumulator immediate wrong");
	a_string_move_len: assert property (
		in_valid && byte0[7:1] == 7'h52 |=> op_q == lsbd_pkg::OP_STR_MOVE && length_q == 4'h1)
		else $error("string move not one byte");
	a_far_exit_adjust: assert property (
		in_valid && byte0 == 8'hCA
		|=> reload_code_seg_q && stack_adjust_q == {$past(byte2), $past(byte1)} && length_q == 4'h3)
		else $error("far exit with adjust wrong");
	a_branch_less_cond: assert property (
		in_valid && byte0 == 8'h7C |=> branch_taken_q == ($past(flag_sign) != $past(flag_overflow)))
		else $error("signed less condition wrong");
	a_branch_target_calc: assert property (
		in_valid && byte0[7:4] == 4'h7
		|=> branch_target_q == $past(instr_addr) + 16'h0002 + {{8{$past(byte1[7])}}, $past(byte1)})
		else $error("branch target wrong");
	a_repeat_zero_match: assert property (
		in_valid && byte0[7:1] == 7'h79 ##1 in_valid && byte0 == 8'hAE
		|=> repeat_q && repeat_zf_match_q == $past(byte0[0], 2))
		else $error("repeat match value lost");

	c_shift_by_count: cover property (in_valid && byte0 == 8'hD3 ##1 out_valid_q && count_from_reg_q);
	c_repeated_compare: cover property (out_valid_q && repeat_q && op_q == lsbd_pkg::OP_STR_COMPARE);
	c_branch_taken: cover property (out_valid_q && class_q == lsbd_pkg::CLS_BRANCH && branch_taken_q);
	c_far_exit: cover property (out_valid_q && op_q == lsbd_pkg::OP_EXIT_FAR);
endmodule : lsbd_decoder
`default_nettype wire

// File: tb/lsbd_feed.sv
// prefetch and execution-unit model that presents instructions to the decoder
`timescale 1ns/100ps
`default_nettype none
module lsbd_feed (
	input wire logic clk,
	output logic in_valid,
	output logic [7:0] byte0,
	output logic [7:0] byte1,
	output logic [7:0] byte2,
	output logic [7:0] byte3,
	output logic [7:0] byte4,
	output logic [7:0] byte5,
	output logic [15:0] instr_addr,
	output logic [7:0] count_low_byte,
	output logic flag_zero,
	output logic flag_sign,
	output logic flag_overflow,
	output logic flag_carry
);
	// idle values at time zero
	initial begin
		in_valid = 1'b0;
		{byte0, byte1, byte2, byte3, byte4, byte5} = 48'h0;
		{instr_addr, count_low_byte} = 24'h0;
		{flag_zero, flag_sign, flag_overflow, flag_carry} = 4'h0;
	end
	// one instruction for one edge; bytes past it are junk
	task automatic send(input logic [31:0] ib, input logic [15:0] a, input logic [3:0] f, input logic [7:0] c);
		@(posedge clk);
		in_valid <= 1'b1;
		{byte0, byte1, byte2, byte3, byte4, byte5} <= {ib, ~ib[15:0]};
		instr_addr <= a;
		{flag_zero, flag_sign, flag_overflow, flag_carry} <= f;
		count_low_byte <= c;
		@(posedge clk);
		in_valid <= 1'b0;
		// released bytes flip so stale values never match
		{byte0, byte1, byte2, byte3, byte4, byte5} <= ~{ib, ~ib[15:0]};
	endtask : send
	// two instructions on consecutive edges, no idle cycle between them
	task automatic send_pair(input logic [31:0] ia, input logic [31:0] ib);
		@(posedge clk);
		in_valid <= 1'b1;
		{byte0, byte1, byte2, byte3, byte4, byte5} <= {ia, ~ia[15:0]};
		@(posedge clk);
		{byte0, byte1, byte2, byte3, byte4, byte5} <= {ib, ~ib[15:0]};
		@(posedge clk);
		in_valid <= 1'b0;
		{byte0, byte1, byte2, byte3, byte4, byte5} <= ~{ib, ~ib[15:0]};
	endtask : send_pair
endmodule : lsbd_feed
`default_nettype wire

// File: tb/test_logic_string_branch_decoder.sv
// self-checking bench for the logic, string, exit and branch decoder
`timescale 1ns/100ps
`default_nettype none
module test_logic_string_branch_decoder;
	logic clk = 1'b0; // core clock
	logic srst = 1'b1; // sync reset
	int miscompares = 0;
	int checks = 0;
	wire logic iv, fz, fs, fo, fc;
	wire logic [7:0] b0, b1, b2, b3, b4, b5, cnt;
	wire logic [15:0] ad;
	// 250 MHz
	always #2 clk = ~clk;
	lsbd_feed feed (.clk(clk), .in_valid(iv), .byte0(b0), .byte1(b1), .byte2(b2), .byte3(b3), .byte4(b4),
		.byte5(b5), .instr_addr(ad), .count_low_byte(cnt), .flag_zero(fz), .flag_sign(fs),
		.flag_overflow(fo), .flag_carry(fc));
	lsbd_decoder uut (.clk(clk), .srst(srst), .in_valid(iv), .byte0(b0), .byte1(b1), .byte2(b2), .byte3(b3),
		.byte4(b4), .byte5(b5), .instr_addr(ad), .count_low_byte(cnt), .flag_zero(fz), .flag_sign(fs),
		.flag_overflow(fo), .flag_carry(fc), .in_ready(), .out_valid_q(), .claimed_q(), .class_q(), .op_q(),
		.word_op_q(), .reg_is_dest_q(), .write_back_q(), .has_modrm_q(), .mod_q(), .reg_q(), .rm_q(),
		.disp_q(), .imm_valid_q(), .imm_q(), .acc_operand_q(), .count_from_reg_q(), .shift_count_q(),
		.repeat_q(), .repeat_zf_match_q(), .branch_taken_q(), .branch_target_q(), .stack_adjust_q(),
		.reload_code_seg_q(), .length_q());
	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// send one instruction, judge operation, length and ownership
	task automatic dec(input logic [31:0] ib, input lsbd_pkg::lsbd_op_type eo, input logic [3:0] el);
		feed.send(ib, 16'h7FF8, 4'h0, 8'h05);
		#1;
		chk("valid", 16'h1, uut.out_valid_q);
		chk("op", eo, uut.op_q);
		chk("length", el, uut.length_q);
		chk("claimed", el != 4'h0, uut.claimed_q);
		chk("ready", 16'h1, uut.in_ready);
	endtask : dec
	// every middle field of the shift group, both count sources
	task automatic t_shift;
		lsbd_pkg::lsbd_op_type ops [8];
		ops = '{lsbd_pkg::OP_ROT_LEFT, lsbd_pkg::OP_ROT_RIGHT, lsbd_pkg::OP_ROT_LEFT_C, lsbd_pkg::OP_ROT_RIGHT_C,
			lsbd_pkg::OP_SHIFT_LEFT, lsbd_pkg::OP_LOGIC_RIGHT, lsbd_pkg::OP_NONE, lsbd_pkg::OP_ARITH_RIGHT};
		for (int i = 0; i < 8; i++) begin
			dec({8'hD3, 2'h3, 3'(i), 3'h1, 16'h0}, ops[i], (i == 6) ? 4'h0 : 4'h2);
			if (i != 6) begin
				chk("count", 16'h5, uut.shift_count_q);
				chk("cnt src", 16'h1, uut.count_from_reg_q);
				chk("word", 16'h1, uut.word_op_q);
			end
		end
		dec(32'hD0E0_0000, lsbd_pkg::OP_SHIFT_LEFT, 4'h2);
		chk("count", 16'h1, uut.shift_count_q);
		chk("cnt src", 16'h0, uut.count_from_reg_q);
		chk("word", 16'h0, uut.word_op_q);
	endtask : t_shift
	// and, or, xor with differing displacement sizes
	task automatic t_logic;
		dec(32'h2345_80AA, lsbd_pkg::OP_AND, 4'h3);
		chk("disp", 16'hFF80, uut.disp_q);
		chk("modrm", 16'h1, uut.has_modrm_q);
		chk("mod", 16'h1, uut.mod_q);
		chk("reg", 16'h0, uut.reg_q);
		chk("rm", 16'h5, uut.rm_q);
		chk("dest", 16'h1, uut.reg_is_dest_q);
		chk("wb", 16'h1, uut.write_back_q);
		dec(32'h0806_3412, lsbd_pkg::OP_OR, 4'h4);
		chk("disp", 16'h1234, uut.disp_q);
		chk("dest", 16'h0, uut.reg_is_dest_q);
		dec(32'h31C1_0000, lsbd_pkg::OP_XOR, 4'h2);
	endtask : t_logic
	// flag-only and forms, including a refused middle field
	task automatic t_flag;
		dec(32'h85C0_0000, lsbd_pkg::OP_FLAG_AND, 4'h2);
		chk("wb", 16'h0, uut.write_back_q);
		chk("immv", 16'h0, uut.imm_valid_q);
		dec(32'hF7C0_3412, lsbd_pkg::OP_FLAG_AND, 4'h4);
		chk("imm", 16'h1234, uut.imm_q);
		chk("immv", 16'h1, uut.imm_valid_q);
		dec(32'hF6C0_AB00, lsbd_pkg::OP_FLAG_AND, 4'h3);
		chk("imm", 16'h00AB, uut.imm_q);
		dec(32'hF6D0_0000, lsbd_pkg::OP_NONE, 4'h0);
		dec(32'hA978_5600, lsbd_pkg::OP_FLAG_AND, 4'h3);
		chk("imm", 16'h5678, uut.imm_q);
		chk("acc", 16'h1, uut.acc_operand_q);
		dec(32'hA878_0000, lsbd_pkg::OP_FLAG_AND, 4'h2);
	endtask : t_flag
	// prefix alone, then its string operation
	task automatic pre(input logic [7:0] p);
		feed.send({p, 24'h0}, 16'h7FF8, 4'h0, 8'h05);
		#1;
		chk("class", lsbd_pkg::CLS_PREFIX, uut.class_q);
		chk("length", 16'h1, uut.length_q);
	endtask : pre
	task automatic t_string;
		dec(32'hA500_0000, lsbd_pkg::OP_STR_MOVE, 4'h1);
		chk("word", 16'h1, uut.word_op_q);
		dec(32'hA600_0000, lsbd_pkg::OP_STR_COMPARE, 4'h1);
		dec(32'hAF00_0000, lsbd_pkg::OP_STR_SEARCH, 4'h1);
		dec(32'hAC00_0000, lsbd_pkg::OP_STR_LOAD, 4'h1);
		chk("acc", 16'h1, uut.acc_operand_q);
		dec(32'hAA00_0000, lsbd_pkg::OP_STR_WRITE, 4'h1);
		pre(8'hF3);
		dec(32'hA600_0000, lsbd_pkg::OP_STR_COMPARE, 4'h1);
		chk("rep", 16'h1, uut.repeat_q);
		chk("zf", 16'h1, uut.repeat_zf_match_q);
		pre(8'hF2);
		dec(32'hAE00_0000, lsbd_pkg::OP_STR_SEARCH, 4'h1);
		chk("zf", 16'h0, uut.repeat_zf_match_q);
		feed.send_pair(32'hF300_0000, 32'hAE00_0000);
		#1;
		chk("op", lsbd_pkg::OP_STR_SEARCH, uut.op_q);
		chk("rep", 16'h1, uut.repeat_q);
		chk("zf", 16'h1, uut.repeat_zf_match_q);
		dec(32'hA400_0000, lsbd_pkg::OP_STR_MOVE, 4'h1);
		chk("rep", 16'h0, uut.repeat_q);
	endtask : t_string
	// all four procedure exits
	task automatic t_exit;
		dec(32'hC300_0000, lsbd_pkg::OP_EXIT_NEAR, 4'h1);
		chk("seg", 16'h0, uut.reload_code_seg_q);
		dec(32'hCB00_0000, lsbd_pkg::OP_EXIT_FAR, 4'h1);
		chk("seg", 16'h1, uut.reload_code_seg_q);
		dec(32'hC234_1200, lsbd_pkg::OP_EXIT_NEAR, 4'h3);
		chk("adj", 16'h1234, uut.stack_adjust_q);
		dec(32'hCA78_5600, lsbd_pkg::OP_EXIT_FAR, 4'h3);
		chk("adj", 16'h5678, uut.stack_adjust_q);
		chk("seg", 16'h1, uut.reload_code_seg_q);
	endtask : t_exit
	// every branch under every flag combination, displacements of both signs
	task automatic t_branch;
		logic [7:0] opc [5];
		logic tk;
		opc = '{8'h74, 8'h7C, 8'h7E, 8'h72, 8'h76};
		for (int k = 0; k < 5; k++) begin
			for (int f = 0; f < 16; f++) begin
				feed.send({opc[k], f[3:0], 4'h8, 16'h0}, 16'h7FF8, f[3:0], 8'h05);
				case (k)
					0: tk = f[3];
					1: tk = f[2] ^ f[1];
					2: tk = (f[2] ^ f[1]) | f[3];
					3: tk = f[0];
					default: tk = f[0] | f[3];
				endcase
				#1;
				chk("op", 16'(lsbd_pkg::OP_BR_EQUAL + k), uut.op_q);
				chk("disp", 16'h0, uut.disp_q);
				chk("taken", tk, uut.branch_taken_q);
				chk("target", 16'h7FFA + {{8{f[3]}}, f[3:0], 4'h8}, uut.branch_target_q);
				chk("length", 16'h2, uut.length_q);
			end
		end
	endtask : t_branch
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		chk("rst count", 16'h1, uut.shift_count_q);
		chk("rst valid", 16'h0, uut.out_valid_q);
		t_shift;
		t_logic;
		t_flag;
		t_string;
		t_exit;
		t_branch;
		complete_run;
	end
	// watchdog
	initial begin
		#20000;
		miscompares++;
		complete_run;
	end
endmodule : test_logic_string_branch_decoder
`default_nettype wire
